// ---- audio_cfg_pkg.sv ----
`default_nettype none
package audio_cfg_pkg;
   // Register word offset (the configuration word sits at the base)
   localparam logic [7:0]  CFG_OFFSET          = 8'h00;
   // Field positions
   localparam int          RX_TH_LSB           = 12;
   localparam int          TX_TH_LSB           = 8;
   localparam int          POLICY_BIT          = 6;
   localparam int          CODEC_BIT           = 5;
   localparam int          FORMAT_BIT          = 4;
   localparam int          SOFT_RST_BIT        = 3;
   localparam int          BCK_DIR_BIT         = 2;
   localparam int          SYNC_DIR_BIT        = 1;
   localparam int          ENABLE_BIT          = 0;
   // Value after reset
   localparam logic [31:0] CFG_RESET           = 32'h0000_7800;
   // Writable bits: 15:8 and 6:0 except the self-clearing bit 3
   localparam logic [31:0] CFG_RW_MASK         = 32'h0000_FF77;
   // Frame sync for the AC-link, 48 kHz from a 10 MHz clock
   localparam int          CLK_HZ              = 10_000_000;
   localparam int          FRAME_HZ            = 48_000;
   localparam int          FRAME_CYCLES        = CLK_HZ / FRAME_HZ;
   // Sync pulse length within the frame, in cycles
   localparam int          SYNC_HIGH_CYCLES    = 2;
   // I2S slave/master role encodings
   typedef enum logic [3:0]
   {
      ROLE_SLAVE       = 4'b0001,
      ROLE_MASTER_EXT  = 4'b0010,
      ROLE_RESERVED    = 4'b0100,
      ROLE_MASTER      = 4'b1000
   } role_e;
endpackage
`default_nettype wire

// ---- audio_link_config_control.sv ----
// How it works
// - Receive flag when level >= 2*(threshold+1)
// - Transmit flag when level <= 2*threshold
// - Reserved bits ignore writes, read zero
// - Underflow sends zero or repeats last
// - Codec select: external 0, internal 1
// - Format select: AC-link 0, I2S 1
// - Soft reset pulses, reads zero
// - Bit clock driven only I2S, direction set
// - Sync direction honoured only in I2S
// - Global enable gates controller operation
// - Direction pair selects slave/master role
// - Disabled: outputs low, directions from config
// - AC-link sync driven at 48 kHz
`timescale 1ns/1ps
`default_nettype none
module audio_link_config_control
   import audio_cfg_pkg::*;
#(
   parameter int LEVEL_W = 6              // FIFO level width, 32 samples
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                cfg_write,          // Register write strobe
   input  wire logic [31:0]         cfg_wdata,          // Register write data
   output logic      [31:0]         audio_link_configuration, // Read data
   input  wire logic [LEVEL_W-1:0]  receive_fifo_level,
   input  wire logic [LEVEL_W-1:0]  transmit_fifo_level,
   output logic                     receive_service_flag,
   output logic                     transmit_service_flag,
   output logic                     controller_reset,   // Soft reset pulse
   output logic                     global_enable,
   output logic                     format_select,
   output logic                     codec_select,
   output logic                     underflow_sample_policy,
   input  wire logic [31:0]         tx_fifo_sample,     // Head of transmit FIFO
   input  wire logic                tx_underflow,       // FIFO empty on demand
   input  wire logic                tx_sample_take,     // Shifter takes a sample
   output logic      [31:0]         tx_sample_out,      // Sample sent on link
   output role_e                    i2s_role,
   input  wire logic                bit_clock_in,       // Internal bit clock
   input  wire logic                sync_in,            // Internal I2S sync
   output logic                     bit_clock_out,
   output logic                     bit_clock_oe,
   output logic                     sync_out,
   output logic                     sync_oe
);

   // All state of the block
   typedef struct packed
   {
      logic [31:0]          cfg;       // Stored configuration bits
      logic                 srst;      // Soft reset pulse
      logic                 rx_flag;   // Receive service flag
      logic                 tx_flag;   // Transmit service flag
      logic [31:0]          last;      // Last sample taken from FIFO
      logic [31:0]          sample;    // Sample presented to shifter
      logic [15:0]          frame_cnt; // AC-link frame counter
      logic                 bck;       // Registered bit clock out
      logic                 bck_oe;
      logic                 snc;       // Registered sync out
      logic                 snc_oe;
   } state_s;

   state_s st;
   state_s next_st;

   logic [LEVEL_W+1:0] rx_limit;   // 2*(threshold+1)
   logic [LEVEL_W+1:0] tx_limit;   // 2*threshold
   logic               fmt_i2s;
   logic               en;
   logic               frame_end;

   // Threshold arithmetic shared by both flags
   function automatic logic [LEVEL_W+1:0] twice(input logic [4:0] v);
      twice = (LEVEL_W+2)'({v, 1'b0});
   endfunction

   // Next-state logic
   always_comb
   begin
      next_st = st;
      en = st.cfg[ENABLE_BIT];
      fmt_i2s = st.cfg[FORMAT_BIT];
      next_st.srst = 1'b0;
      if (cfg_write)
      begin
         next_st.cfg = cfg_wdata & CFG_RW_MASK;
         next_st.srst = cfg_wdata[SOFT_RST_BIT];
      end
      rx_limit = twice({1'b0, st.cfg[RX_TH_LSB +: 4]} + 5'h01);
      next_st.rx_flag = en && ((LEVEL_W+2)'(receive_fifo_level) >= rx_limit);
      tx_limit = twice({1'b0, st.cfg[TX_TH_LSB +: 4]});
      next_st.tx_flag = en && ((LEVEL_W+2)'(transmit_fifo_level) <= tx_limit);
      if (!en || st.srst)
      begin
         next_st.sample = 32'h0000_0000;
         next_st.last = 32'h0000_0000;
      end
      else if (tx_sample_take)
      begin
         if (tx_underflow)
            next_st.sample = st.cfg[POLICY_BIT] ? st.last : 32'h0000_0000;
         else
         begin
            next_st.sample = tx_fifo_sample;
            next_st.last = tx_fifo_sample;
         end
      end
      frame_end = (st.frame_cnt == 16'(FRAME_CYCLES - 1));
      if (!en || fmt_i2s || frame_end || st.srst)
         next_st.frame_cnt = 16'h0000;
      else
         next_st.frame_cnt = st.frame_cnt + 16'h0001;
      // bit clock direction, AC-link always input
      next_st.bck_oe = fmt_i2s && st.cfg[BCK_DIR_BIT];
      next_st.bck = en && next_st.bck_oe && bit_clock_in;
      next_st.snc_oe = fmt_i2s ? st.cfg[SYNC_DIR_BIT] : 1'b1;
      if (!en)
         next_st.snc = 1'b0;
      else if (fmt_i2s)
         next_st.snc = st.cfg[SYNC_DIR_BIT] && sync_in;
      else
         next_st.snc = (st.frame_cnt < 16'(SYNC_HIGH_CYCLES));
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st <= '{cfg: CFG_RESET, default: '0};
      end
      else
         st <= next_st;
   end

   // Register read back; soft reset bit reads zero
   assign audio_link_configuration = st.cfg;
   assign receive_service_flag     = st.rx_flag;
   assign transmit_service_flag    = st.tx_flag;
   assign controller_reset         = st.srst;
   assign global_enable            = st.cfg[ENABLE_BIT];
   assign format_select            = st.cfg[FORMAT_BIT];
   assign codec_select             = st.cfg[CODEC_BIT];
   assign underflow_sample_policy  = st.cfg[POLICY_BIT];
   assign tx_sample_out            = st.sample;
   assign bit_clock_out            = st.bck;
   assign bit_clock_oe             = st.bck_oe;
   assign sync_out                 = st.snc;
   assign sync_oe                  = st.snc_oe;

   // Role decode from the direction pair
   always_comb
   begin
      case ({st.cfg[BCK_DIR_BIT], st.cfg[SYNC_DIR_BIT]})
         2'b00:   i2s_role = ROLE_SLAVE;
         2'b01:   i2s_role = ROLE_MASTER_EXT;
         2'b10:   i2s_role = ROLE_RESERVED;
         default: i2s_role = ROLE_MASTER;
      endcase
   end

   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      audio_link_configuration[31:16] == 16'h0000 && !audio_link_configuration[7])
      else $error("reserved bits nonzero");

   cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_write |=> audio_link_configuration == ($past(cfg_wdata) & CFG_RW_MASK))
      else $error("register write wrong");

   cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg_write |=> $stable(audio_link_configuration))
      else $error("register changed without write");

   srst_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_write && cfg_wdata[3] |=> controller_reset && !audio_link_configuration[3])
      else $error("soft reset not pulsed");

   srst_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_write && !cfg_wdata[SOFT_RST_BIT] |=> !controller_reset)
      else $error("soft reset without request");

   srst_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      controller_reset |=> tx_sample_out == 32'h0000_0000)
      else $error("sample kept over soft reset");

   rx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && (32'(receive_fifo_level) >= 2 * (32'(audio_link_configuration[15:12]) + 1))
      && !cfg_write |=> receive_service_flag)
      else $error("receive flag missing");

   rx_flag_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && (32'(receive_fifo_level) < 2 * (32'(audio_link_configuration[15:12]) + 1))
      |=> !receive_service_flag)
      else $error("receive flag early");

   tx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && (32'(transmit_fifo_level) > 2 * 32'(audio_link_configuration[11:8]))
      |=> !transmit_service_flag)
      else $error("transmit flag wrong");

   tx_flag_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && (32'(transmit_fifo_level) <= 2 * 32'(audio_link_configuration[11:8]))
      |=> transmit_service_flag)
      else $error("transmit flag missing");

   flags_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
      !global_enable |=> !receive_service_flag && !transmit_service_flag)
      else $error("flag raised while disabled");

   disabled_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
      !global_enable |=> tx_sample_out == 32'h0000_0000)
      else $error("sample sent while disabled");

   zero_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && !controller_reset && tx_sample_take && tx_underflow && !underflow_sample_policy
      |=> tx_sample_out == 32'h0000_0000)
      else $error("underflow not zero");

   last_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && !controller_reset && tx_sample_take && tx_underflow && underflow_sample_policy
      |=> tx_sample_out == $past(st.last))
      else $error("underflow not repeated");

   codec_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_write |=> codec_select == $past(cfg_wdata[CODEC_BIT]))
      else $error("codec select wrong");

   format_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_write |=> format_select == $past(cfg_wdata[FORMAT_BIT]))
      else $error("format select wrong");

   aclink_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
      !format_select |=> !bit_clock_oe)
      else $error("bit clock driven in AC-link");

   i2s_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
      format_select |=> bit_clock_oe == $past(audio_link_configuration[BCK_DIR_BIT]))
      else $error("bit clock direction wrong");

   clock_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && format_select && audio_link_configuration[BCK_DIR_BIT]
      |=> bit_clock_out == $past(bit_clock_in))
      else $error("bit clock not forwarded");

   i2s_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
      format_select |=> sync_oe == $past(audio_link_configuration[SYNC_DIR_BIT]))
      else $error("sync direction wrong");

   sync_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && format_select
      |=> sync_out == $past(audio_link_configuration[SYNC_DIR_BIT] && sync_in))
      else $error("sync not forwarded");

   aclink_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
      !format_select |=> sync_oe)
      else $error("sync not driven in AC-link");

   disabled_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      !global_enable && !cfg_write |=> !bit_clock_out && !sync_out)
      else $error("outputs not low");

   role_slave_a: assert property (@(posedge clk) disable iff (!rst_n)
      !audio_link_configuration[BCK_DIR_BIT] && !audio_link_configuration[SYNC_DIR_BIT]
      |-> i2s_role == ROLE_SLAVE)
      else $error("slave role wrong");

   role_master_a: assert property (@(posedge clk) disable iff (!rst_n)
      audio_link_configuration[BCK_DIR_BIT] && audio_link_configuration[SYNC_DIR_BIT]
      |-> i2s_role == ROLE_MASTER)
      else $error("master role wrong");

   frame_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      st.frame_cnt < 16'(FRAME_CYCLES))
      else $error("frame counter overrun");

   aclink_sync_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && !format_select && st.frame_cnt == 16'h0000 |=> sync_out)
      else $error("frame sync missing");

   aclink_sync_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_enable && !format_select && st.frame_cnt == 16'(SYNC_HIGH_CYCLES) |=> !sync_out)
      else $error("frame sync too long");
endmodule
`default_nettype wire

// ---- audio_link_config_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_link_config_control_tb;
   import audio_cfg_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, cfg_write = 1'b0, run = 1'b0;
   logic        tx_underflow = 1'b0, tx_sample_take = 1'b0, bck, syn;
   logic [31:0] cfg_wdata = 32'h0, tx_fifo_sample = 32'h0, rd, smp;
   logic [5:0]  rx_lvl = 6'h00, tx_lvl = 6'h00;
   logic        rsf, tsf, crst, en, fmt, cdc, pol, bco, bcoe, so, soe;
   role_e       role;
   int          err_total = 0, num_checks = 0, cyc = 0, hi;
   // Clock, 100 ns period
   always #50 clk = ~clk;
   audio_link_config_control uut (.clk(clk), .rst_n(rst_n), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
      .audio_link_configuration(rd), .receive_fifo_level(rx_lvl), .transmit_fifo_level(tx_lvl),
      .receive_service_flag(rsf), .transmit_service_flag(tsf), .controller_reset(crst),
      .global_enable(en), .format_select(fmt), .codec_select(cdc), .underflow_sample_policy(pol),
      .tx_fifo_sample(tx_fifo_sample), .tx_underflow(tx_underflow), .tx_sample_take(tx_sample_take),
      .tx_sample_out(smp), .i2s_role(role), .bit_clock_in(bck), .sync_in(syn), .bit_clock_out(bco),
      .bit_clock_oe(bcoe), .sync_out(so), .sync_oe(soe));
   codec_link_model codec (.clk(clk), .run(run), .bit_clock_in(bck), .sync_in(syn));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Advance one cycle, land just after the edge
   task automatic step;
      @(posedge clk);
      #10;
   endtask
   // One register write
   task automatic wr(input logic [31:0] d);
      cfg_write = 1'b1;
      cfg_wdata = d;
      step();
      cfg_write = 1'b0;
   endtask
   task automatic print_verdict;
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (16) @(posedge clk);
      #10;
      rst_n = 1'b1;
      chk(rd, 32'h0000_7800);
      wr(32'hFFFF_FFFF);
      chk(rd, 32'h0000_FF77);
      chk(crst, 1'b1);
      chk({pol, cdc, fmt, en}, 4'hF);
      step();
      chk(crst, 1'b0);
      // Every direction pair, written with the bit clock stopped
      for (int i = 0; i < 4; i++)
      begin
         wr(32'h0000_0011 | (i << 1));
         chk(role, 32'h1 << i);
         step();
         chk({bcoe, soe}, i[1:0]);
      end
      // Disabled: directions kept, outputs low
      wr(32'h0000_0016);
      step();
      chk({bcoe, bco, so}, 3'b100);
      // AC-link: sync high cycles over one frame, codec clock running
      wr(32'h0000_0007);
      run = 1'b1;
      step();
      chk({bcoe, soe}, 2'b01);
      hi = 0;
      repeat (208)
      begin
         step();
         hi += so;
      end
      chk(hi, SYNC_HIGH_CYCLES);
      run = 1'b0;
      // Thresholds at both ends of the field
      for (int k = 0; k < 16; k += 15)
      begin
         wr({16'h0, k[3:0], k[3:0], 8'h01});
         for (int lv = 2 * k; lv <= 2 * k + 2; lv++)
         begin
            rx_lvl = lv[5:0];
            tx_lvl = lv[5:0];
            step();
            step();
            chk(rsf, lv >= 2 * k + 2);
            chk(tsf, lv <= 2 * k);
         end
      end
      wr(32'h0);
      step();
      chk(rsf, 1'b0);
      // Underflow with each policy
      for (int p = 0; p < 2; p++)
      begin
         wr(32'h0000_0001 | (p << 6));
         tx_fifo_sample = 32'h1234_5678;
         tx_sample_take = 1'b1;
         step();
         tx_underflow = 1'b1;
         tx_fifo_sample = 32'hDEAD_BEEF;
         step();
         tx_sample_take = 1'b0;
         tx_underflow = 1'b0;
         step();
         chk(smp, p ? 32'h1234_5678 : 32'h0);
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- codec_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far-side codec: supplies a bit clock and a frame sync while running
module codec_link_model
(
   input  wire logic clk,
   input  wire logic run,
   output logic      bit_clock_in,
   output logic      sync_in
);
   logic [4:0] phase; // Position in the frame, cleared while stopped
   always_ff @(posedge clk)
   begin
      phase <= run ? phase + 5'h01 : 5'h00;
   end
   // Clock stands low while stopped, so stale edges never leak out
   assign bit_clock_in = run & phase[0];
   assign sync_in      = run & phase[4];
endmodule
`default_nettype wire
